// ---- hdl/dcso_ctrl.sv ----
`include "dcso_consts.svh"

module dcso_ctrl
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [`DCSO_ADDR_W-1:0] reg_addr,
   input wire logic [`DCSO_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`DCSO_FRAME_W-1:0] reg_rdata,
   input wire logic force_clear_n,
   input wire logic load_output_n,
   output logic [`DCSO_DATA_W-1:0] dac_code,
   output logic output_float,
   output logic output_ground_clamp,
   output logic [1:0] output_mode,
   output logic feedback_resistor_select,
   output logic offset_binary,
   output logic [3:0] lin_comp
);

   ////////////////////////////////////////////////////////////////////////
   // declarations

   // the whole state lives in one struct, registered in one place
   dcso_pkg::dcso_state_type st_ff;
   dcso_pkg::dcso_state_type nxt_st;
   // synchronised pin levels, active low like the pins themselves
   logic [`DCSO_NPINS-1:0] pins_sync_n;
   logic clear_pin_low;
   logic load_pin_low;
   logic sw_load;
   logic sw_clear;
   logic sw_reset;
   logic strobe_wr;

   ////////////////////////////////////////////////////////////////////////
   // functions

   // power-on contents of every register
   // the drive code starts at the negative reference with the output clamped
   function automatic dcso_pkg::dcso_state_type dcso_reset_state();
      dcso_pkg::dcso_state_type s;
      s.pending = `DCSO_DAC_RST;
      s.active = `DCSO_DAC_RST;
      s.written = 1'b0;
      s.clear_value = `DCSO_CLEAR_RST;
      s.output_float = `DCSO_FLOAT_RST;
      s.output_ground_clamp = `DCSO_CLAMP_RST;
      s.feedback_resistor_select = `DCSO_FBSEL_RST;
      s.offset_binary = `DCSO_BIN_RST;
      s.lin_comp = `DCSO_LIN_RST;
      s.drive_code = `DCSO_DAC_RST;
      s.rdata = `DCSO_RDATA_RST;
      return s;
   endfunction

   // converts a register code in the selected coding to the offset-binary
   // code the converter core needs; twos complement only flips the msb
   function automatic logic [`DCSO_DATA_W-1:0] dcso_to_core
   (
      input logic [`DCSO_DATA_W-1:0] code,
      input logic bin
   );
      logic [`DCSO_DATA_W-1:0] r;
      r = bin ? code : (code ^ `DCSO_MSB_FLIP);
      return r;
   endfunction

   // output state from the two control bits, one branch per truth-table row;
   // the clamp bit wins over the float bit so the pin never floats unloaded
   function automatic dcso_pkg::dcso_out_mode_type dcso_out_mode
   (
      input logic flt,
      input logic clamp
   );
      dcso_pkg::dcso_out_mode_type m;
      case ({flt, clamp})
         2'h0:
         begin
            m = dcso_pkg::DCSO_OUT_NORMAL;
         end
         2'h1:
         begin
            m = dcso_pkg::DCSO_OUT_CLAMPED;
         end
         2'h2:
         begin
            m = dcso_pkg::DCSO_OUT_TRISTATE;
         end
         2'h3:
         begin
            m = dcso_pkg::DCSO_OUT_CLAMPED;
         end
         default:
         begin
            // only reached with unknown inputs; fall back to the safe state
            m = dcso_pkg::DCSO_OUT_CLAMPED;
         end
      endcase
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // read-back and decode helpers

   // address compare for the strobe decode
   function automatic logic dcso_hit
   (
      input logic [`DCSO_ADDR_W-1:0] addr,
      input logic [`DCSO_ADDR_W-1:0] code
   );
      logic h;
      h = (addr == code);
      return h;
   endfunction

   // read frame: direction bit set, address echoed, data in the low bits
   function automatic logic [`DCSO_FRAME_W-1:0] dcso_frame
   (
      input logic [`DCSO_ADDR_W-1:0] addr,
      input logic [`DCSO_DATA_W-1:0] data
   );
      logic [`DCSO_FRAME_W-1:0] f;
      f = {1'h1, addr, data};
      return f;
   endfunction

   // control register as it reads back; built from the field positions so a
   // moved field cannot leave a stale bit behind, unused bits read zero
   function automatic logic [`DCSO_DATA_W-1:0] dcso_ctrl_word
   (
      input dcso_pkg::dcso_state_type s
   );
      logic [`DCSO_DATA_W-1:0] w;
      w = 20'h00000;
      w[`DCSO_CTRL_FBSEL] = s.feedback_resistor_select;
      w[`DCSO_CTRL_CLAMP] = s.output_ground_clamp;
      w[`DCSO_CTRL_FLOAT] = s.output_float;
      w[`DCSO_CTRL_BIN] = s.offset_binary;
      w[`DCSO_CTRL_LIN_HI:`DCSO_CTRL_LIN_LO] = s.lin_comp;
      return w;
   endfunction

   // code handed to the converter core; until the input register has been
   // written or cleared once, the core sits at the negative reference
   // and a change of coding alone moves nothing
   function automatic logic [`DCSO_DATA_W-1:0] dcso_drive
   (
      input logic written,
      input logic [`DCSO_DATA_W-1:0] code,
      input logic bin
   );
      logic [`DCSO_DATA_W-1:0] d;
      if (written)
      begin
         d = dcso_to_core(code, bin);
      end
      else
      begin
         d = `DCSO_DAC_RST;
      end
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; the pins come from outside the clock domain
   // a pin change acts on the third edge; a low pulse shorter than one
   // cycle can slip between samples, so pins must be held one cycle or more

   dcso_pin_sync u_pin_sync
   (
      .core_clk(core_clk),
      .resetn(resetn),
      .pins_n({load_output_n, force_clear_n}),
      .pins_sync_n(pins_sync_n)
   );

   assign clear_pin_low = !pins_sync_n[`DCSO_PIN_CLEAR];
   assign load_pin_low = !pins_sync_n[`DCSO_PIN_LOAD];

   ////////////////////////////////////////////////////////////////////////
   // software strobe decode; only the three low bits mean anything

   // a write to the strobe register is a single-cycle event, never stored;
   // reserved bits above bit 2 reach no logic at all
   assign strobe_wr = reg_wr && dcso_hit(reg_addr, `DCSO_ADDR_STROBE);
   // reset is never masked: it must work whatever the pins are doing
   assign sw_reset = strobe_wr && reg_wdata[`DCSO_SW_RESET];
   // the opposite pin held low masks the strobe completely
   assign sw_clear = strobe_wr && reg_wdata[`DCSO_SW_CLEAR] && !load_pin_low;
   assign sw_load = strobe_wr && reg_wdata[`DCSO_SW_LOAD] && !clear_pin_low;

   ////////////////////////////////////////////////////////////////////////
   // next-state logic

   always_comb
   begin
      nxt_st = st_ff;
      // read data stand for exactly one cycle after the read strobe
      nxt_st.rdata = `DCSO_RDATA_RST;

      // register writes; the strobe register has no storage at all
      // a write lands at the edge that samples the strobe, visible one cycle on
      if (reg_wr)
      begin
         case (reg_addr)
            `DCSO_ADDR_DAC:
            begin
               nxt_st.pending = reg_wdata;
               nxt_st.written = 1'b1;
            end
            `DCSO_ADDR_CTRL:
            begin
               nxt_st.feedback_resistor_select = reg_wdata[`DCSO_CTRL_FBSEL];
               nxt_st.output_ground_clamp = reg_wdata[`DCSO_CTRL_CLAMP];
               nxt_st.output_float = reg_wdata[`DCSO_CTRL_FLOAT];
               nxt_st.offset_binary = reg_wdata[`DCSO_CTRL_BIN];
               // every 4-bit code is stored as is, 1100 included
               nxt_st.lin_comp = reg_wdata[`DCSO_CTRL_LIN_HI:`DCSO_CTRL_LIN_LO];
            end
            `DCSO_ADDR_CLEAR:
            begin
               nxt_st.clear_value = reg_wdata;
            end
            default:
            begin
               // strobe register and unused codes keep no state
               nxt_st = nxt_st;
            end
         endcase
      end

      // register reads return the frame with the direction bit set; the data
      // come from the state as it stood at the read edge, so a write in the
      // cycle before is already visible for the control and clear registers
      if (reg_rd)
      begin
         case (reg_addr)
            `DCSO_ADDR_DAC:
            begin
               nxt_st.rdata = dcso_frame(reg_addr, st_ff.active);
            end
            `DCSO_ADDR_CTRL:
            begin
               nxt_st.rdata = dcso_frame(reg_addr, dcso_ctrl_word(st_ff));
            end
            `DCSO_ADDR_CLEAR:
            begin
               nxt_st.rdata = dcso_frame(reg_addr, st_ff.clear_value);
            end
            default:
            begin
               // write-only strobe register and unused codes read as zero data
               nxt_st.rdata = dcso_frame(reg_addr, 20'h00000);
            end
         endcase
      end

      // output update: clear pin first, then clear strobe, then loads
      // a held clear pin copies the clear value every cycle, so a new clear
      // value written meanwhile shows on the edge after the write lands
      if (clear_pin_low)
      begin
         // held low keeps the output at the clear value
         nxt_st.active = st_ff.clear_value;
         nxt_st.written = 1'b1;
      end
      else if (sw_clear)
      begin
         nxt_st.active = st_ff.clear_value;
         nxt_st.written = 1'b1;
      end
      else if (sw_load || load_pin_low)
      begin
         // a load behaves as a single low pulse on the load pin
         // with the load pin held low the output follows the pending register
         nxt_st.active = st_ff.pending;
      end

      // coded drive value for the converter core
      nxt_st.drive_code = dcso_drive(nxt_st.written, nxt_st.active, nxt_st.offset_binary);

      // software reset overrides everything else in the same cycle
      // the pin synchronisers keep running: they only mirror the pins, and
      // resetting them would show a false release for two cycles
      if (sw_reset)
      begin
         nxt_st = dcso_reset_state();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   // synchronous reset shares its value function with the reset strobe

   always_ff @(posedge core_clk)
   begin
      if (!resetn)
      begin
         st_ff <= dcso_reset_state();
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all from the state register
   // output_mode is a decode of two flops, so it changes only with them

   assign reg_rdata = st_ff.rdata;
   assign dac_code = st_ff.drive_code;
   assign output_float = st_ff.output_float;
   assign output_ground_clamp = st_ff.output_ground_clamp;
   // the host must clear both bits before normal operation starts
   assign output_mode = dcso_out_mode(st_ff.output_float, st_ff.output_ground_clamp);
   assign feedback_resistor_select = st_ff.feedback_resistor_select;
   assign offset_binary = st_ff.offset_binary;
   assign lin_comp = st_ff.lin_comp;

endmodule

// ---- hdl/dcso_consts.svh ----
`ifndef DCSO_CONSTS_SVH
`define DCSO_CONSTS_SVH

// widths of the register port and of the 24-bit frame
`define DCSO_ADDR_W 3
`define DCSO_DATA_W 20
`define DCSO_FRAME_W 24
`define DCSO_RW_BIT 23

// register address codes
`define DCSO_ADDR_DAC 3'h1
`define DCSO_ADDR_CTRL 3'h2
`define DCSO_ADDR_CLEAR 3'h3
`define DCSO_ADDR_STROBE 3'h4

// control register field positions
`define DCSO_CTRL_FBSEL 1
`define DCSO_CTRL_CLAMP 2
`define DCSO_CTRL_FLOAT 3
`define DCSO_CTRL_BIN 4
`define DCSO_CTRL_LIN_LO 6
`define DCSO_CTRL_LIN_HI 9

// software strobe register bit positions
`define DCSO_SW_LOAD 0
`define DCSO_SW_CLEAR 1
`define DCSO_SW_RESET 2

// reset and fixed values
`define DCSO_CLEAR_RST 20'h00000
`define DCSO_DAC_RST 20'h00000
`define DCSO_LIN_RST 4'h0
`define DCSO_LIN_20V 4'hC
`define DCSO_MSB_FLIP 20'h80000
`define DCSO_FLOAT_RST 1'b1
`define DCSO_CLAMP_RST 1'b1
`define DCSO_FBSEL_RST 1'b0
`define DCSO_BIN_RST 1'b1
`define DCSO_RDATA_RST 24'h000000

// number of synchronised pins: bit 0 force_clear_n, bit 1 load_output_n
`define DCSO_NPINS 2
`define DCSO_PIN_CLEAR 0
`define DCSO_PIN_LOAD 1

`endif

// ---- hdl/dcso_pkg.sv ----
`include "dcso_consts.svh"

package dcso_pkg;

   // complete state of the control block
   typedef struct packed {
      logic [`DCSO_DATA_W-1:0] pending;
      logic [`DCSO_DATA_W-1:0] active;
      logic written;
      logic [`DCSO_DATA_W-1:0] clear_value;
      logic output_float;
      logic output_ground_clamp;
      logic feedback_resistor_select;
      logic offset_binary;
      logic [3:0] lin_comp;
      logic [`DCSO_DATA_W-1:0] drive_code;
      logic [`DCSO_FRAME_W-1:0] rdata;
   } dcso_state_type;

   // output state seen by the analog section
   typedef enum logic [1:0] {
      DCSO_OUT_NORMAL = 2'h0,
      DCSO_OUT_TRISTATE = 2'h1,
      DCSO_OUT_CLAMPED = 2'h3
   } dcso_out_mode_type;

endpackage

// ---- hdl/dcso_pin_sync.sv ----
`include "dcso_consts.svh"

// two-flop synchroniser for the active-low control pins
module dcso_pin_sync
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [`DCSO_NPINS-1:0] pins_n,
   output logic [`DCSO_NPINS-1:0] pins_sync_n
);

   logic [`DCSO_NPINS-1:0] meta_ff;
   logic [`DCSO_NPINS-1:0] sync_ff;

   ////////////////////////////////////////////////////////////////////////
   // one pair of flops per pin; idle level is high so reset reads released
   genvar gi;
   generate
      for (gi = 0; gi < `DCSO_NPINS; gi = gi + 1)
      begin : g_pin
         always_ff @(posedge core_clk)
         begin
            if (!resetn)
            begin
               meta_ff[gi] <= 1'b1;
               sync_ff[gi] <= 1'b1;
            end
            else
            begin
               meta_ff[gi] <= pins_n[gi];
               sync_ff[gi] <= meta_ff[gi];
            end
         end
      end
   endgenerate

   assign pins_sync_n = sync_ff;

endmodule

// ---- verification/dcso_ctrl_props.sv ----
`include "dcso_consts.svh"
////////////////////////////////////////
// port-level checks of the control block
module dcso_ctrl_props
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [2:0] reg_addr,
   input wire logic [19:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [23:0] reg_rdata,
   input wire logic force_clear_n,
   input wire logic [19:0] dac_code,
   input wire logic output_float,
   input wire logic output_ground_clamp,
   input wire logic [1:0] output_mode,
   input wire logic [3:0] lin_comp
);
   timeunit 1ns;
   timeprecision 1ps;
   // field copied to a net so the past value is of a plain signal
   logic [3:0] lin_w;
   assign lin_w = reg_wdata[9:6];
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // reset strobe write; clear pin held with no register writes
   sequence sw_rst;
      reg_wr && reg_addr == `DCSO_ADDR_STROBE && reg_wdata[`DCSO_SW_RESET];
   endsequence
   sequence clr_quiet;
      (!force_clear_n && !reg_wr) [*6];
   endsequence
   a_mode_clamp: assert property (output_ground_clamp |-> output_mode == 2'h3)
      else $error("clamp set, mode wrong");
   a_mode_float: assert property (output_float && !output_ground_clamp |-> output_mode == 2'h1)
      else $error("float set, mode wrong");
   a_mode_normal: assert property (!output_float && !output_ground_clamp |-> output_mode == 2'h0)
      else $error("normal mode wrong");
   a_read_frame: assert property (reg_rd |=> reg_rdata[23:20] == {1'b1, $past(reg_addr)})
      else $error("read frame head wrong");
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 24'h000000)
      else $error("read data not idle");
   a_strobe_rd: assert property (reg_rd && reg_addr == `DCSO_ADDR_STROBE |=> reg_rdata[19:0] == 20'h00000)
      else $error("strobe register readable");
   a_soft_reset: assert property (sw_rst |=> output_float && output_ground_clamp && lin_comp == 4'h0 && dac_code == 20'h00000)
      else $error("soft reset state wrong");
   a_lin_update: assert property (reg_wr && reg_addr == `DCSO_ADDR_CTRL |=> lin_comp == $past(lin_w))
      else $error("span field not written");
   a_clear_hold: assert property (clr_quiet |-> $stable(dac_code))
      else $error("code moved under clear");
endmodule
bind dcso_ctrl dcso_ctrl_props u_props (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .force_clear_n, .dac_code, .output_float, .output_ground_clamp,
   .output_mode, .lin_comp);

// ---- verification/dcso_pin_host.sv ----
////////////////////////////////////////
// host side of the two active-low control pins
module dcso_pin_host
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic clear_req,
   input wire logic load_req,
   output logic force_clear_n,
   output logic load_output_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // pins idle high; a request holds its pin low as a level
   always_ff @(posedge core_clk)
   begin
      force_clear_n <= !(clear_req && resetn);
      load_output_n <= !(load_req && resetn);
   end
endmodule

// ---- verification/tb_top.sv ----
////////////////////////////////////////
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, resetn, reg_wr, reg_rd, clear_req, load_req;
   logic force_clear_n, load_output_n, output_float, output_ground_clamp;
   logic feedback_resistor_select, offset_binary;
   logic [1:0] output_mode;
   logic [2:0] reg_addr;
   logic [3:0] lin_comp;
   logic [19:0] reg_wdata, dac_code;
   logic [23:0] reg_rdata;
   int fails, comparisons, test_no;
   dcso_ctrl dut (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .force_clear_n, .load_output_n, .dac_code, .output_float, .output_ground_clamp,
      .output_mode, .feedback_resistor_select, .offset_binary, .lin_comp);
   dcso_pin_host host (.core_clk, .resetn, .clear_req, .load_req, .force_clear_n,
      .load_output_n);
   // 100 MHz clock
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(string what, logic [23:0] got, logic [23:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // one-cycle strobes; a gap cycle between calls keeps each strobe a single pulse
   task automatic wr(logic [2:0] a, logic [19:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(logic [2:0] a, logic [19:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk("read frame", reg_rdata, {1'b1, a, d});
   endtask
   task automatic st(logic [9:0] s, logic [19:0] d);
      chk("state", {14'h0000, output_ground_clamp, output_float, output_mode,
         feedback_resistor_select, offset_binary, lin_comp}, {14'h0000, s});
      chk("dac code", {4'h0, dac_code}, {4'h0, d});
   endtask
   // pin levels need the synchroniser plus one edge to show
   task automatic pins(logic c, logic l);
      @(posedge core_clk);
      clear_req <= c;
      load_req <= l;
      repeat (6) @(posedge core_clk);
      #1;
   endtask
   task automatic tend;
      test_no++;
      $display("test %0d finished", test_no);
   endtask
   task automatic complete_run;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // watchdog far beyond the fewer than a hundred cycles the tests need
   initial
   begin
      #50000;
      fails++;
      complete_run;
   end
   initial
   begin
      {reg_wr, reg_rd, clear_req, load_req, resetn} = 5'h00;
      reg_addr = 3'h0;
      reg_wdata = 20'h00000;
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      #1;
      st(10'h3D0, 20'h00000);
      rd(3'h3, 20'h00000);
      tend;
      wr(3'h2, 20'h00312);
      st(10'h03C, 20'h00000);
      wr(3'h1, 20'h12345);
      st(10'h03C, 20'h00000);
      wr(3'h4, 20'h00001);
      st(10'h03C, 20'h12345);
      rd(3'h1, 20'h12345);
      tend;
      wr(3'h3, 20'h0ABCD);
      rd(3'h3, 20'h0ABCD);
      wr(3'h2, 20'h00302);
      wr(3'h4, 20'h00002);
      st(10'h02C, 20'h8ABCD);
      wr(3'h4, 20'hFFFF8);
      st(10'h02C, 20'h8ABCD);
      rd(3'h4, 20'h00000);
      tend;
      pins(1'b0, 1'b1);
      st(10'h02C, 20'h92345);
      wr(3'h4, 20'h00002);
      st(10'h02C, 20'h92345);
      pins(1'b1, 1'b0);
      st(10'h02C, 20'h8ABCD);
      wr(3'h1, 20'h00001);
      wr(3'h4, 20'h00001);
      st(10'h02C, 20'h8ABCD);
      pins(1'b0, 1'b0);
      tend;
      wr(3'h2, 20'h00008);
      st(10'h140, 20'h8ABCD);
      wr(3'h2, 20'h0000C);
      wr(3'h5, 20'h00001);
      st(10'h3C0, 20'h8ABCD);
      rd(3'h7, 20'h00000);
      wr(3'h4, 20'h00004);
      st(10'h3D0, 20'h00000);
      rd(3'h3, 20'h00000);
      tend;
      complete_run;
   end
endmodule
